// file: common/gpu_pkg.sv
`default_nettype none
package gpu_pkg;
    // Register byte offsets, one aligned word each
    localparam logic [5:0] OFF_PA_DATA = 6'h00;
    localparam logic [5:0] OFF_PA_DIR = 6'h04;
    localparam logic [5:0] OFF_PA_PULLUP = 6'h08;
    localparam logic [5:0] OFF_PA_WAKE = 6'h0c;
    localparam logic [5:0] OFF_PB_DATA = 6'h10;
    localparam logic [5:0] OFF_PB_DIR = 6'h14;
    localparam logic [5:0] OFF_PB_PULLUP = 6'h18;
    localparam logic [5:0] OFF_PC_DATA = 6'h20;
    localparam logic [5:0] OFF_PC_DIR = 6'h24;
    localparam logic [5:0] OFF_PC_PULLUP = 6'h28;
    localparam logic [5:0] OFF_PD_DATA = 6'h30;
    localparam logic [5:0] OFF_PD_DIR = 6'h34;
    localparam logic [5:0] OFF_PD_PULLUP = 6'h38;
    localparam logic [5:0] OFF_BIT_OP = 6'h3c;
    localparam logic [5:0] OFF_SLEEP = 6'h2c;
    // Bit-op command word fields
    localparam int BITOP_IDX_LSB = 0;
    localparam int BITOP_PORT_LSB = 4;
    localparam int BITOP_SET_BIT = 8;
    // Reset values
    localparam logic [7:0] RST_DATA = 8'hff;
    localparam logic [7:0] RST_DIR = 8'hff;
    localparam logic [7:0] RST_ZERO = 8'h00;
    // Masks of implemented bits
    localparam logic [7:0] MASK_PA_PULLUP = 8'h7f;
    localparam logic [7:0] MASK_PB = 8'h3f;
    localparam logic [7:0] MASK_PD = 8'h0f;
    localparam logic [7:0] MASK_PC_NARROW = 8'h0f;
    localparam logic [7:0] MASK_FULL = 8'hff;
    // Per-port pin control carrier
    typedef struct packed {
        logic [7:0] driveEn;
        logic [7:0] driveVal;
        logic [7:0] pullEn;
    } gpu_pin_ctl_t;
endpackage
`default_nettype wire

// file: verilog/gpu_ports.sv
// Notes on behaviour
// - Port reads sample synchronised pin level at the read strobe, no earlier latch
// - Output latch holds its value until software writes it again
// - Direction bit 1 makes pin input, 0 makes it a driven output
// - Input pins read back the pin level
// - Output pins read back the pin status, not the latch
// - Direction can be rewritten any time and takes effect next cycle
// - Pull-up enable bit 1 connects weak pull-up, 0 disconnects
// - Pull-up only acts while the pin is an input
// - Port A bit seven has no pull-up; its bit is unimplemented
// - Halt command enters sleep with the core clock gated off
// - In sleep, a falling edge on an enabled Port A pin wakes
// - Each Port A pin has its own wake enable bit
// - Unimplemented direction, pull-up and wake bits read as zero
// - Reset clears wake and pull-up; sets implemented direction bits
// - Reset sets data latches and direction registers high
// - Bit set or clear reads whole port, modifies bit, writes all back
//
// Register access over Avalon-MM and the address map were chosen for this implementation.
`default_nettype none
module gpu_ports #(
    parameter bit PC_WIDE = 1'b1 // Port C has eight pins when set, four otherwise
) (
    input wire logic clk, // 20 MHz system clock
    input wire logic reset, // Synchronous, active high
    input wire logic [5:0] avs_address, // Byte address
    input wire logic avs_read, // Read request
    input wire logic avs_write, // Write request
    input wire logic [31:0] avs_writedata, // Write data
    input wire logic [3:0] avs_byteenable, // Byte lanes
    output logic [31:0] avs_readdata, // Read data, registered
    output logic avs_waitrequest, // Stall until answer ready
    input wire logic [7:0] paIn, // Port A pin levels
    output logic [7:0] paOut, // Port A drive value
    output logic [7:0] paOe, // Port A drive enable
    output logic [7:0] paPull, // Port A pull-up on
    input wire logic [7:0] pbIn, // Port B pin levels
    output logic [7:0] pbOut, // Port B drive value
    output logic [7:0] pbOe, // Port B drive enable
    output logic [7:0] pbPull, // Port B pull-up on
    input wire logic [7:0] pcIn, // Port C pin levels
    output logic [7:0] pcOut, // Port C drive value
    output logic [7:0] pcOe, // Port C drive enable
    output logic [7:0] pcPull, // Port C pull-up on
    input wire logic [7:0] pdIn, // Port D pin levels
    output logic [7:0] pdOut, // Port D drive value
    output logic [7:0] pdOe, // Port D drive enable
    output logic [7:0] pdPull, // Port D pull-up on
    output logic sleeping, // High while core clock is stopped
    output logic wakeUp // One-cycle pulse on wake
);
    localparam logic [7:0] MASK_PC = PC_WIDE ? gpu_pkg::MASK_FULL : gpu_pkg::MASK_PC_NARROW;
    // Implemented-bit masks per port
    logic [7:0] dataMask [4];
    logic [7:0] pullMask [4];
    assign dataMask[0] = gpu_pkg::MASK_FULL;
    assign dataMask[1] = gpu_pkg::MASK_PB;
    assign dataMask[2] = MASK_PC;
    assign dataMask[3] = gpu_pkg::MASK_PD;
    assign pullMask[0] = gpu_pkg::MASK_PA_PULLUP;
    assign pullMask[1] = gpu_pkg::MASK_PB;
    assign pullMask[2] = MASK_PC;
    assign pullMask[3] = gpu_pkg::MASK_PD;

    // Two-stage synchronisers on all pins; only stage two is read
    logic [7:0] pinMeta [4];
    logic [7:0] pinSync [4];
    logic [7:0] pinRaw [4];
    assign pinRaw[0] = paIn;
    assign pinRaw[1] = pbIn;
    assign pinRaw[2] = pcIn;
    assign pinRaw[3] = pdIn;

    logic [7:0] latchReg [4];
    logic [7:0] dirReg [4];
    logic [7:0] pullReg [4];
    logic [7:0] wakeReg;
    logic [7:0] pinStatus [4];
    gpu_pkg::gpu_pin_ctl_t pinCtl [4];

    // Request decode
    logic [1:0] portSel;
    logic [1:0] regSel;
    logic isPortSpace;
    logic wrAcc;
    logic [7:0] wrByte;
    logic bitOpPending;
    logic [1:0] bitOpPort;
    logic [2:0] bitOpIdx;
    logic bitOpSet;
    assign portSel = avs_address[5:4];
    assign regSel = avs_address[3:2];
    assign isPortSpace = (regSel != 2'd3);
    assign wrAcc = avs_write && !avs_waitrequest && avs_byteenable[0];
    assign wrByte = avs_writedata[7:0];

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : gPort
            // Pin synchroniser, two flops
            always_ff @(posedge clk) begin
                if (reset) begin
                    pinMeta[g] <= gpu_pkg::RST_ZERO;
                    pinSync[g] <= gpu_pkg::RST_ZERO;
                end else begin
                    pinMeta[g] <= pinRaw[g];
                    pinSync[g] <= pinMeta[g];
                end
            end

            // Pin status: level seen at the pin whichever direction
            assign pinStatus[g] = pinSync[g] & dataMask[g];

            // Output latch: only changes on a write or bit-op write-back
            always_ff @(posedge clk) begin
                if (reset) begin
                    latchReg[g] <= gpu_pkg::RST_DATA & dataMask[g];
                end else if (bitOpPending && bitOpPort == g) begin
                    // Whole port read, one bit changed, all written back
                    latchReg[g] <= next_bitop(pinStatus[g], bitOpIdx, bitOpSet) & dataMask[g];
                end else if (wrAcc && portSel == g && regSel == 2'd0) begin
                    latchReg[g] <= wrByte & dataMask[g];
                end
            end

            // Direction, changeable any time
            always_ff @(posedge clk) begin
                if (reset) begin
                    dirReg[g] <= gpu_pkg::RST_DIR & dataMask[g];
                end else if (wrAcc && portSel == g && regSel == 2'd1) begin
                    dirReg[g] <= wrByte & dataMask[g];
                end
            end

            // Pull-up enables
            always_ff @(posedge clk) begin
                if (reset) begin
                    pullReg[g] <= gpu_pkg::RST_ZERO;
                end else if (wrAcc && portSel == g && regSel == 2'd2) begin
                    pullReg[g] <= wrByte & pullMask[g];
                end
            end

            // Pin drive: 0 in direction drives CMOS output
            assign pinCtl[g].driveEn = ~dirReg[g] & dataMask[g];
            assign pinCtl[g].driveVal = latchReg[g];
            assign pinCtl[g].pullEn = pullReg[g] & dirReg[g];
        end
    endgenerate

    assign paOe = pinCtl[0].driveEn;
    assign paOut = pinCtl[0].driveVal;
    assign paPull = pinCtl[0].pullEn;
    assign pbOe = pinCtl[1].driveEn;
    assign pbOut = pinCtl[1].driveVal;
    assign pbPull = pinCtl[1].pullEn;
    assign pcOe = pinCtl[2].driveEn;
    assign pcOut = pinCtl[2].driveVal;
    assign pcPull = pinCtl[2].pullEn;
    assign pdOe = pinCtl[3].driveEn;
    assign pdOut = pinCtl[3].driveVal;
    assign pdPull = pinCtl[3].pullEn;

    function automatic logic [7:0] next_bitop(input logic [7:0] cur, input logic [2:0] idx,
                                              input logic setIt);
        logic [7:0] v;
        v = cur;
        v[idx] = setIt;
        return v;
    endfunction

    // Bit-op command: captured, then applied on the next cycle from fresh pin status
    always_ff @(posedge clk) begin
        if (reset) begin
            bitOpPending <= 1'b0;
            bitOpPort <= 2'd0;
            bitOpIdx <= 3'd0;
            bitOpSet <= 1'b0;
        end else begin
            bitOpPending <= wrAcc && avs_address == gpu_pkg::OFF_BIT_OP;
            if (wrAcc && avs_address == gpu_pkg::OFF_BIT_OP) begin
                bitOpPort <= avs_writedata[gpu_pkg::BITOP_PORT_LSB +: 2];
                bitOpIdx <= avs_writedata[gpu_pkg::BITOP_IDX_LSB +: 3];
                bitOpSet <= avs_writedata[gpu_pkg::BITOP_SET_BIT];
            end
        end
    end

    // Wake enables, one per Port A pin
    always_ff @(posedge clk) begin
        if (reset) begin
            wakeReg <= gpu_pkg::RST_ZERO;
        end else if (wrAcc && avs_address == gpu_pkg::OFF_PA_WAKE) begin
            wakeReg <= wrByte;
        end
    end

    // Sleep: halt request stops the core; falling edge on enabled pin wakes.
    // This block keeps running so it can see the edge.
    logic [7:0] paPrev;
    logic wakeHit;
    assign wakeHit = |(paPrev & ~pinSync[0] & wakeReg);
    always_ff @(posedge clk) begin
        if (reset) begin
            paPrev <= gpu_pkg::RST_ZERO;
            sleeping <= 1'b0;
            wakeUp <= 1'b0;
        end else begin
            paPrev <= pinSync[0];
            wakeUp <= 1'b0;
            if (sleeping && wakeHit) begin
                sleeping <= 1'b0;
                wakeUp <= 1'b1;
            end else if (wrAcc && avs_address == gpu_pkg::OFF_SLEEP && wrByte[0]) begin
                sleeping <= 1'b1;
            end
        end
    end

    // Read mux: pin level sampled at the first edge of the request, one cycle before the accept edge
    logic [7:0] rdByte;
    always_comb begin
        rdByte = 8'h00;
        if (avs_address == gpu_pkg::OFF_PA_WAKE) begin
            rdByte = wakeReg;
        end else if (avs_address == gpu_pkg::OFF_SLEEP) begin
            rdByte = {7'h00, sleeping};
        end else if (isPortSpace && avs_address[1:0] == 2'b00) begin
            case (regSel)
                2'd0: rdByte = pinStatus[portSel];
                2'd1: rdByte = dirReg[portSel];
                2'd2: rdByte = pullReg[portSel];
                default: rdByte = 8'h00;
            endcase
        end
    end

    // Bus slave: one wait cycle, answer on the second edge; unmapped reads give zero
    logic answerReady;
    assign avs_waitrequest = (avs_read || avs_write) && !answerReady;
    always_ff @(posedge clk) begin
        if (reset) begin
            answerReady <= 1'b0;
            avs_readdata <= 32'h0000_0000;
        end else begin
            answerReady <= (avs_read || avs_write) && !answerReady;
            if (avs_read && !answerReady) begin
                avs_readdata <= {24'h00_0000, rdByte};
            end
        end
    end
endmodule
`default_nettype wire

// file: tb/gpu_ports_asserts.sv
`default_nettype none
module gpu_ports_asserts (
    input wire logic clk, // System clock
    input wire logic reset, // Sync reset
    input wire logic [5:0] avs_address, // Bus address
    input wire logic avs_read, // Read request
    input wire logic avs_write, // Write request
    input wire logic [31:0] avs_readdata, // Read data
    input wire logic avs_waitrequest, // Bus stall
    input wire logic [7:0] paOut, // Port A latch
    input wire logic [7:0] paOe, // Port A drive
    input wire logic [7:0] paPull, // Port A pull
    input wire logic [7:0] pbPull, // Port B pull
    input wire logic [7:0] pdPull, // Port D pull
    input wire logic sleeping, // Halted
    input wire logic wakeUp // Wake pulse
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // Pin controls
    AST_PULL_INPUT: assert property ((paPull & paOe) == 8'h00)
        else $error("pull-up active on a driven pin");
    AST_PA7_NOPULL: assert property (paPull[7] == 1'b0)
        else $error("pull-up on port A bit seven");
    AST_ABSENT_PULL: assert property (pbPull[7:6] == 2'h0 && pdPull[3:0] == pdPull)
        else $error("pull-up on an absent pin");
    // Reset itself must be checked, so this one is never disabled
    AST_RESET_STATE: assert property (disable iff (1'b0) reset |=>
        (paOe == 8'h00 && paPull == 8'h00 && paOut == 8'hff && !sleeping))
        else $error("port A not in reset state");
    // Bus answers after exactly one wait cycle
    AST_WAIT_ONE: assert property ($rose(avs_read || avs_write) |->
        avs_waitrequest ##1 !avs_waitrequest)
        else $error("wait cycle count wrong");
    AST_DIR_CAUSE: assert property ($changed(paOe) |-> $past(avs_write))
        else $error("drive enable moved without a write");
    // Bit operations land one cycle after the accept
    AST_LATCH_HOLD: assert property ($changed(paOut) |->
        ($past(avs_write) || $past(avs_write, 2)))
        else $error("latch moved without a write");
    AST_HALT: assert property ($rose(sleeping) |->
        ($past(avs_write) && $past(avs_address) == gpu_pkg::OFF_SLEEP))
        else $error("sleep entered without halt");
    AST_WAKE: assert property (wakeUp |-> ($past(sleeping) && !sleeping) ##1 !wakeUp)
        else $error("wake pulse malformed");
    AST_READ_UPPER: assert property (avs_read && !avs_waitrequest |->
        avs_readdata[31:8] == 24'h0)
        else $error("upper read bits set");
    COV_WAKE: cover property (wakeUp);
    COV_HALT: cover property ($rose(sleeping));
    COV_READ: cover property (avs_read && !avs_waitrequest);
endmodule
bind gpu_ports gpu_ports_asserts i_gpu_ports_asserts (.clk(clk), .reset(reset),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .paOut(paOut),
    .paOe(paOe), .paPull(paPull), .pbPull(pbPull), .pdPull(pdPull),
    .sleeping(sleeping), .wakeUp(wakeUp));
`default_nettype wire

// file: tb/gpu_pin_model.sv
`default_nettype none
module gpu_pin_model (
    input wire logic clk, // System clock
    input wire logic [31:0] oe, // Device drive enables
    input wire logic [31:0] out, // Device drive values
    input wire logic [31:0] pull, // Device pull-ups
    input wire logic [31:0] extEn, // Outside driver on
    input wire logic [31:0] extVal, // Outside level
    output logic [31:0] pins // Resolved pin levels
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] flt = 32'h0;
    // Floating pins toggle so no stale level can pass as valid
    always_ff @(posedge clk) flt <= ~flt;
    // Device wins, then outside driver, then pull-up, else float
    assign pins = (oe & out) | (~oe & extEn & extVal) | (~oe & ~extEn & pull)
        | (~oe & ~extEn & ~pull & flt);
endmodule
`default_nettype wire

// file: tb/testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [5:0] avs_address = 6'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] extVal = 32'h0;
    logic [31:0] extEn = 32'h0;
    wire logic [31:0] avs_readdata, pins, outAll, oeAll, pullAll;
    wire logic avs_waitrequest, sleeping, wakeUp;
    int err_total = 0;
    int compares = 0;
    int seed = 32'h53203f9d;
    logic [7:0] dir[4], pu[4], lat[4];
    logic [7:0] im[4] = '{8'hff, 8'h3f, 8'hff, 8'h0f};
    logic [7:0] pm[4] = '{8'h7f, 8'h3f, 8'hff, 8'h0f};
    gpu_ports i_gpu_ports (.clk(clk), .reset(reset), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .paIn(pins[7:0]), .paOut(outAll[7:0]), .paOe(oeAll[7:0]), .paPull(pullAll[7:0]),
        .pbIn(pins[15:8]), .pbOut(outAll[15:8]), .pbOe(oeAll[15:8]), .pbPull(pullAll[15:8]),
        .pcIn(pins[23:16]), .pcOut(outAll[23:16]), .pcOe(oeAll[23:16]),
        .pcPull(pullAll[23:16]), .pdIn(pins[31:24]), .pdOut(outAll[31:24]),
        .pdOe(oeAll[31:24]), .pdPull(pullAll[31:24]), .sleeping(sleeping), .wakeUp(wakeUp));
    gpu_pin_model i_gpu_pin_model (.clk(clk), .oe(oeAll), .out(outAll), .pull(pullAll),
        .extEn(extEn), .extVal(extVal), .pins(pins));
    initial forever #25 clk = ~clk;
    // Expected pin status: outputs show the latch, inputs the outside level, or the pull-up level where no outside driver is on
    function automatic logic [7:0] pinx(int p);
        logic [7:0] e;
        e = extEn[8*p+:8];
        return (lat[p] & ~dir[p]) | (dir[p] & e & extVal[8*p+:8]) | (dir[p] & ~e & pu[p]);
    endfunction
    // One bus cycle; held until an edge sees waitrequest low, only the watchdog ends a hang
    task automatic bus(input bit w, input logic [5:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic summarize();
        $display("mismatches %0d compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Hang guard, far beyond the expected run
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        summarize();
    end
    // Main sequence
    initial begin
        logic [31:0] q;
        logic [31:0] r;
        logic [7:0] e8;
        int p;
        int b;
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        for (p = 0; p < 4; p++) begin
            dir[p] = im[p];
            pu[p] = 8'h00;
            lat[p] = im[p];
            bus(0, 6'(16 * p + 4), 0, q);
            chk("dir", q, im[p]);
            bus(0, 6'(16 * p + 8), 0, q);
            chk("pull", q, 0);
            chk("out", outAll[8*p+:8] & im[p], im[p]);
        end
        bus(0, gpu_pkg::OFF_PA_WAKE, 0, q);
        chk("wake", q, 0);
        bus(1, 6'h1c, 32'hff, q);
        bus(0, 6'h1c, 0, q);
        chk("unmapped", q, 0);
        for (int i = 0; i < 16; i++) begin
            p = i % 4;
            r = $random(seed);
            bus(1, 6'(16 * p + 4), r, q);
            dir[p] = r[7:0] & im[p];
            r = $random(seed);
            bus(1, 6'(16 * p + 8), r, q);
            pu[p] = r[7:0] & pm[p];
            r = $random(seed);
            bus(1, 6'(16 * p), r, q);
            lat[p] = r[7:0];
            extEn[8*p+:8] <= dir[p] & ~pu[p];
            extVal[8*p+:8] <= $random(seed);
            repeat (4) @(posedge clk);
            bus(0, 6'(16 * p + 4), 0, q);
            chk("dir", q, dir[p]);
            bus(0, 6'(16 * p + 8), 0, q);
            chk("pull", q, pu[p]);
            bus(0, 6'(16 * p), 0, q);
            chk("data", q, pinx(p) & im[p]);
            chk("oe", oeAll[8*p+:8] & im[p], ~dir[p] & im[p]);
            chk("latch", outAll[8*p+:8] & ~dir[p] & im[p], lat[p] & ~dir[p] & im[p]);
            chk("pullpin", pullAll[8*p+:8] & im[p], pu[p] & dir[p]);
            b = $random(seed) & 7;
            e8 = pinx(p);
            e8[b] = r[9];
            bus(1, gpu_pkg::OFF_BIT_OP, {23'h0, r[9], 2'h0, 2'(p), 1'b0, 3'(b)}, q);
            lat[p] = e8;
            repeat (2) @(posedge clk);
            chk("rmw", outAll[8*p+:8] & im[p], lat[p] & im[p]);
        end
        bus(1, gpu_pkg::OFF_PA_DIR, 32'hff, q);
        bus(1, gpu_pkg::OFF_PA_PULLUP, 0, q);
        extEn[7:0] <= 8'hff;
        extVal[7:0] <= 8'hff;
        bus(1, gpu_pkg::OFF_PA_WAKE, 32'h01, q);
        bus(0, gpu_pkg::OFF_PA_WAKE, 0, q);
        chk("wakeen", q, 32'h01);
        bus(1, gpu_pkg::OFF_SLEEP, 32'h1, q);
        extVal[1] <= 1'b0;
        @(negedge clk);
        chk("halt", sleeping, 1);
        repeat (6) @(posedge clk);
        chk("nowake", sleeping, 1);
        extVal[0] <= 1'b0;
        for (b = 0; wakeUp !== 1'b1 && b < 10; b++) @(negedge clk);
        chk("wakeup", wakeUp, 1);
        chk("awake", sleeping, 0);
        summarize();
    end
endmodule
`default_nettype wire
